/* File: mmd_pkg.sv */
/*
 memory map decoder package: address map constants, mode and boot loader
 enumerations, register offsets and the packed carriers of the block.
 assumes a 16-bit cpu address space with byte-wide data.
*/
`default_nettype none
package mmd_pkg;
	// ==========================================================
	// address map
	localparam logic [15:0] MMD_BOOT_JUMP_ADDR = 16'h0000;
	localparam logic [15:0] MMD_BOOT_ENTRY = 16'hbf40;
	localparam logic [15:0] MMD_JUMP_TABLE_BASE = 16'h00c4;
	localparam logic [7:0] MMD_BOOT_PAGE = 8'hbf;
	localparam logic [7:0] MMD_BOOT_VEC_LOW = 8'hc0;
	localparam logic [15:0] MMD_VECTOR_BASE = 16'hffc0;
	localparam logic [11:0] MMD_REG_BLOCK_BYTES = 12'h060;
	localparam logic [11:0] MMD_RAM_BYTES = 12'h400;
	localparam logic [2:0] MMD_NVM_OFFSET_TOP = 3'h7;
	localparam logic [3:0] MMD_NVM_TEST_HOLE = 4'hd;
	localparam logic [3:0] MMD_NVM_DEFAULT_PAGE = 4'hf;
	localparam logic [9:0] MMD_RAM_LAST = 10'h3ff;
	// ==========================================================
	// register offsets and reset values
	localparam logic [7:0] MMD_OFS_MAP_POS = 8'h00;
	localparam logic [7:0] MMD_OFS_OPTION = 8'h04;
	localparam logic [7:0] MMD_OFS_STATUS = 8'h08;
	localparam logic [7:0] MMD_OFS_CONTROL = 8'h0c;
	localparam logic [3:0] MMD_RST_RAM_PAGE = 4'h0;
	localparam logic [3:0] MMD_RST_REG_PAGE = 4'h1;
	localparam logic MMD_RST_NVM_ON = 1'b1;
	// settle count on which the mode pins are frozen, four edges after reset release
	localparam logic [1:0] MMD_MODE_SETTLE = 2'h3;
	// ==========================================================
	// timing
	localparam int MMD_CLK_HZ = 50000000;
	localparam int MMD_BAUD = 1200;
	localparam int MMD_CHAR_BITS = 10;
	localparam int MMD_IDLE_CHARS = 4;
	localparam int MMD_IDLE_CYCLES =
		(MMD_CLK_HZ / MMD_BAUD) * MMD_CHAR_BITS * MMD_IDLE_CHARS;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		MMD_MODE_BOOT = 2'b00,
		MMD_MODE_TEST = 2'b01,
		MMD_MODE_SINGLE = 2'b10,
		MMD_MODE_EXPANDED = 2'b11
	} mmd_mode_type;
	typedef enum logic [1:0] {
		MMD_BL_IDLE = 2'b00,
		MMD_BL_LOAD = 2'b01,
		MMD_BL_DONE = 2'b11
	} mmd_boot_type;
	typedef struct packed {
		logic regs;
		logic ram;
		logic boot;
		logic nvm;
		logic ext;
		logic none;
	} mmd_sel_type;
	typedef struct packed {
		logic [7:0] addr_high;
		logic [7:0] addr_low;
		logic [7:0] data_out;
		logic data_oe;
		logic read_not_write;
		logic strobe;
	} mmd_exp_type;
endpackage : mmd_pkg
`default_nettype wire

/* File: mmd_decoder.sv */
/*
 memory map decoder: mode capture, address decode with relocation,
 on-chip ram and boot rom, boot download engine and an apb slave for the
 map-position, option, status and control registers.
 assumes the cpu access port and the received-byte port run on clk_sys and
 the mode pins are asynchronous.
 the cpu must wait until the mode is frozen, four edges after reset,
 before its first access. only the select of the register block is made
 here; its contents live elsewhere. the ram has no reset, so its contents
 survive stop and reset.
*/
// Operation
// R01 - mode pins sampled around reset; outside holds them steady through reset
// R02 - expanded accesses go out as high address, low address, data
// R03 - on-chip placement same in single-chip and expanded modes; array here fixed at default page in single-chip, page select in expanded
// R04 - 96-byte register block at 1000 after reset, page movable
// R05 - 1024-byte ram at 0000 after reset, page movable
// R06 - register block beats ram in a shared page
// R07 - enabled nonvolatile array decodes at fe00 after reset
// R08 - expanded and test modes place array at page select, offset e00
// R09 - single-chip and bootstrap force array on at default page
// R10 - entering test mode disables the nonvolatile array
// R11 - test mode blocks zd00-zdff from the external bus
// R12 - test mode vector fetches go to the external bus
// R13 - bootstrap mode boot rom answers whole bf00-bfff
// R14 - bootstrap vectors come from bfc0-bfff, boot code starts
// R15 - boot rom absent in normal modes
// R16 - boot loader stores up to 1024 downloaded bytes into ram
// R17 - jump to 0000 after four idle characters or byte for 03ff
// R18 - serial pins become open-drain; outside pulls transmit high
// R19 - bootstrap vectors point at ram jump table entries
// R20 - direct addressing reaches only the lowest 256 addresses
// R21 - stop state halts clocks, ram kept intact
// R22 - priority registers, ram, boot rom, array; else external if expanded
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder
	import mmd_pkg::*;
#(
	parameter int IDLE_CYCLES = MMD_IDLE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mode pins
	input wire logic mode_select_low,
	input wire logic mode_select_high,
	// cpu access port
	input wire logic cpu_req,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_we,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_vector,
	input wire logic cpu_direct,
	input wire logic wake,
	output mmd_sel_type cpu_sel,
	output logic [7:0] cpu_rdata,
	output mmd_exp_type exp_bus,
	// async_serial_port received bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic serial_open_drain,
	output logic boot_jump,
	output logic [15:0] boot_jump_addr,
	output logic clocks_halted
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0] pin_meta;
		logic [1:0] pin_sync;
		logic [1:0] settle;
		logic mode_frozen;
		mmd_mode_type mode;
		logic [3:0] ram_page;
		logic [3:0] reg_page;
		logic [3:0] nvm_page;
		logic nvm_on;
		logic stop;
		mmd_boot_type boot_state;
		logic [9:0] load_count;
		logic [31:0] idle_count;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		mmd_sel_type sel;
		logic [7:0] rdata;
		mmd_exp_type exp;
		logic open_drain;
		logic jump;
		logic [15:0] jump_addr;
	} mmd_state_type;

	mmd_state_type state_reg, state_next;
	logic [7:0] ram_mem [0:1023];
	logic [7:0] ram_rd;
	logic [15:0] eff_addr;
	mmd_sel_type dec;
	logic cpu_ram_we, load_we;
	logic apb_access, apb_commit;
	logic cpu_taken;

	// ==========================================================
	// decode
	// true when the address falls in the given 4-kbyte page
	function automatic logic mmd_page_hit(input logic [15:0] a,
		input logic [3:0] pg);
		return a[15:12] == pg;
	endfunction

	function automatic mmd_sel_type mmd_decode(
		input logic [15:0] a,
		input mmd_mode_type m,
		input logic [3:0] rg_pg,
		input logic [3:0] rm_pg,
		input logic [3:0] nv_pg_cfg,
		input logic nv_cfg_on,
		input logic vec
	);
		mmd_sel_type s;
		logic [3:0] nv_pg;
		logic nv_on, expd, hole;
		s = '0;
		// forced on at default page in single-chip and bootstrap
		expd = (m == MMD_MODE_EXPANDED) || (m == MMD_MODE_TEST);
		nv_pg = expd ? nv_pg_cfg : MMD_NVM_DEFAULT_PAGE; // [R08] [R09]
		nv_on = expd ? nv_cfg_on : 1'b1; // [R09]
		hole = (m == MMD_MODE_TEST) && mmd_page_hit(a, nv_pg) &&
			(a[11:8] == MMD_NVM_TEST_HOLE);
		if (vec && (m == MMD_MODE_TEST)) begin
			s.ext = 1'b1; // [R12]
		end else if (mmd_page_hit(a, rg_pg) &&
			a[11:0] < MMD_REG_BLOCK_BYTES) begin
			s.regs = 1'b1; // [R04] [R06] [R22]
		end else if (mmd_page_hit(a, rm_pg) &&
			a[11:0] < MMD_RAM_BYTES) begin
			s.ram = 1'b1; // [R05] [R22]
		end else if (m == MMD_MODE_BOOT && a[15:8] == MMD_BOOT_PAGE) begin
			s.boot = 1'b1; // [R13] [R15] [R22]
		end else if (nv_on && mmd_page_hit(a, nv_pg) &&
			a[11:9] == MMD_NVM_OFFSET_TOP) begin
			s.nvm = 1'b1; // [R07] [R08] [R22]
		end else if (expd && !hole) begin
			s.ext = 1'b1; // [R02] [R11] [R22]
		end else begin
			// single-chip or bootstrap unmapped, or test-mode hole: nobody answers
			s.none = 1'b1; // [R03]
		end
		return s;
	endfunction

	// boot rom contents: vectors only; code bytes are not modelled here
	function automatic logic [7:0] mmd_boot_byte(input logic [7:0] ofs);
		logic [15:0] target;
		logic [5:0] vec_idx;
		target = '0;
		vec_idx = 6'(ofs[5:1]);
		if (ofs >= MMD_BOOT_VEC_LOW) begin
			if (ofs[7:1] == 7'h7f) begin
				target = MMD_BOOT_ENTRY; // [R14]
			end else begin
				// three bytes per jump table entry in ram
				target = 16'(MMD_JUMP_TABLE_BASE + 16'(vec_idx) * 16'h0003); // [R19]
			end
		end
		return ofs[0] ? target[7:0] : target[15:8];
	endfunction

	always_comb begin
		// bootstrap vectors fold from the top page onto the boot rom
		if (cpu_direct) begin
			eff_addr = {8'h00, cpu_addr[7:0]}; // [R20]
		end else if (cpu_vector && state_reg.mode == MMD_MODE_BOOT &&
			cpu_addr >= MMD_VECTOR_BASE) begin
			eff_addr = {MMD_BOOT_PAGE, cpu_addr[7:0]}; // [R14]
		end else begin
			eff_addr = cpu_addr;
		end
		dec = mmd_decode(eff_addr, state_reg.mode, state_reg.reg_page,
			state_reg.ram_page, state_reg.nvm_page, state_reg.nvm_on,
			cpu_vector);
	end

	// ==========================================================
	// ram: no reset, so contents survive stop and reset alike
	assign load_we = (state_reg.boot_state == MMD_BL_LOAD) && rx_valid &&
		!state_reg.stop;
	// a stopped core is not taken: no select, no write
	assign cpu_taken = cpu_req && !state_reg.stop; // [R21]
	// loader write wins over a cpu write in the same cycle
	assign cpu_ram_we = cpu_taken && cpu_we && dec.ram && !load_we;

	always_ff @(posedge clk_sys) begin
		if (load_we) begin
			ram_mem[state_reg.load_count] <= rx_data; // [R16]
		end else if (cpu_ram_we) begin
			ram_mem[eff_addr[9:0]] <= cpu_wdata; // [R21]
		end
	end

	// plain array read; the byte is flopped in the state, so cpu_rdata
	// leaves a flop like every other output
	always_comb begin
		ram_rd = ram_mem[eff_addr[9:0]];
	end

	// ==========================================================
	// apb and next state
	assign apb_access = psel && penable;
	assign apb_commit = apb_access && state_reg.pready;

	always_comb begin
		state_next = state_reg;
		state_next.jump = 1'b0;
		state_next.jump_addr = MMD_BOOT_JUMP_ADDR; // [R17]
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;

		// mode pins pass two flops before anything reads them
		state_next.pin_meta = {mode_select_high, mode_select_low};
		state_next.pin_sync = state_reg.pin_meta;
		if (!state_reg.mode_frozen) begin
			// pins must still hold their reset levels while the sync fills;
			// the sync flops reset to zero, which reads as bootstrap, so the
			// mode follows them only once the pin levels have arrived
			if (state_reg.settle[1]) begin
				state_next.mode = mmd_mode_type'(state_reg.pin_sync); // [R01]
			end
			state_next.settle = 2'(state_reg.settle + 2'h1);
			if (state_reg.settle == MMD_MODE_SETTLE) begin
				state_next.mode_frozen = 1'b1;
				if (state_reg.pin_sync == MMD_MODE_TEST) begin
					state_next.nvm_on = 1'b0; // [R10]
				end
				if (state_reg.pin_sync == MMD_MODE_BOOT) begin
					state_next.boot_state = MMD_BL_LOAD;
					state_next.open_drain = 1'b1; // [R18]
				end
			end
		end

		// boot download engine
		case (state_reg.boot_state)
			MMD_BL_IDLE: begin
				state_next.idle_count = '0;
			end
			MMD_BL_LOAD: begin
				// idle time counts from load entry and restarts at each byte; stop pauses it
				if (load_we) begin
					state_next.idle_count = '0;
					state_next.load_count = 10'(state_reg.load_count + 10'h001);
					if (state_reg.load_count == MMD_RAM_LAST) begin
						state_next.boot_state = MMD_BL_DONE; // [R17]
						state_next.jump = 1'b1;
					end
				end else if (state_reg.idle_count >= 32'(IDLE_CYCLES - 1)) begin
					state_next.boot_state = MMD_BL_DONE; // [R17]
					state_next.jump = 1'b1;
				end else if (!state_reg.stop) begin
					state_next.idle_count = 32'(state_reg.idle_count + 32'h1);
				end
			end
			MMD_BL_DONE: begin
				state_next.idle_count = '0;
			end
			default: begin
				state_next.boot_state = MMD_BL_IDLE;
			end
		endcase

		// stop left by wake or by a control write
		if (wake) begin
			state_next.stop = 1'b0;
		end

		// apb: one wait state, then pready for one cycle
		if (apb_access && !state_reg.pready) begin
			state_next.pready = 1'b1;
			state_next.prdata = '0;
			case (paddr)
				MMD_OFS_MAP_POS: state_next.prdata =
					{24'h000000, state_reg.reg_page, state_reg.ram_page};
				MMD_OFS_OPTION: state_next.prdata =
					{27'h0000000, state_reg.nvm_on, state_reg.nvm_page};
				MMD_OFS_STATUS: state_next.prdata =
					{16'h0000, state_reg.load_count, state_reg.boot_state,
					state_reg.mode_frozen, state_reg.stop, state_reg.mode};
				MMD_OFS_CONTROL: state_next.prdata =
					{31'h00000000, state_reg.stop};
				default: state_next.pslverr = 1'b1;
			endcase
		end
		if (apb_commit && pwrite) begin
			case (paddr)
				MMD_OFS_MAP_POS: begin
					state_next.ram_page = pwdata[3:0]; // [R05]
					state_next.reg_page = pwdata[7:4]; // [R04]
				end
				MMD_OFS_OPTION: begin
					state_next.nvm_page = pwdata[3:0]; // [R08]
					state_next.nvm_on = pwdata[4];
				end
				MMD_OFS_CONTROL: begin
					// wake in the same cycle wins over entering stop
					state_next.stop = pwdata[0] && !wake; // [R21]
				end
				default: begin
					state_next.stop = state_next.stop;
				end
			endcase
		end

		// cpu access: selects and expansion bus one cycle after request
		state_next.sel = '0;
		state_next.exp.strobe = 1'b0;
		state_next.exp.data_oe = 1'b0;
		if (cpu_taken) begin
			state_next.sel = dec;
			if (dec.ram) begin
				state_next.rdata = ram_rd; // [R05]
			end
			if (dec.ext) begin
				state_next.exp.addr_high = eff_addr[15:8]; // [R02]
				state_next.exp.addr_low = eff_addr[7:0];
				state_next.exp.data_out = cpu_wdata;
				state_next.exp.data_oe = cpu_we;
				state_next.exp.read_not_write = !cpu_we;
				state_next.exp.strobe = 1'b1;
			end
			if (dec.boot) begin
				state_next.rdata = mmd_boot_byte(eff_addr[7:0]); // [R13]
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.mode <= MMD_MODE_SINGLE;
			state_reg.ram_page <= MMD_RST_RAM_PAGE;
			state_reg.reg_page <= MMD_RST_REG_PAGE;
			state_reg.nvm_page <= MMD_NVM_DEFAULT_PAGE;
			state_reg.nvm_on <= MMD_RST_NVM_ON;
			state_reg.boot_state <= MMD_BL_IDLE;
			state_reg.exp.read_not_write <= 1'b1;
			state_reg.jump_addr <= MMD_BOOT_JUMP_ADDR;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	assign cpu_rdata = state_reg.rdata;
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign cpu_sel = state_reg.sel;
	assign exp_bus = state_reg.exp;
	assign serial_open_drain = state_reg.open_drain;
	assign boot_jump = state_reg.jump;
	assign boot_jump_addr = state_reg.jump_addr; // [R17]
	assign clocks_halted = state_reg.stop;
endmodule // mmd_decoder
`default_nettype wire

/* File: mmd_decoder_sva.sv */
/*
 port checker for mmd_decoder.
 assumes a bind onto mmd_decoder; one clock domain, clk_sys, reset rst.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_sva
	import mmd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_req,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_direct,
	input wire mmd_sel_type cpu_sel,
	input wire mmd_exp_type exp_bus,
	input wire logic serial_open_drain,
	input wire logic boot_jump,
	input wire logic [15:0] boot_jump_addr,
	input wire logic clocks_halted
);
	logic taken;
	assign taken = cpu_req && !clocks_halted;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// apb answer
	property p_apb_answer;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb access not answered in one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("pslverr without pready");
	// ==========================================================
	// decode
	property p_sel_onehot;
		taken |=> $onehot(cpu_sel);
	endproperty
	a_sel_onehot: assert property (p_sel_onehot)
		else $error("cpu access not decoded to one target");
	property p_sel_quiet;
		!taken |=> cpu_sel == '0;
	endproperty
	a_sel_quiet: assert property (p_sel_quiet)
		else $error("select raised without a taken access");
	property p_ext_bus;
		cpu_sel.ext && !$past(cpu_direct) |-> exp_bus.strobe &&
			exp_bus.addr_high == $past(cpu_addr[15:8]) &&
			exp_bus.addr_low == $past(cpu_addr[7:0]);
	endproperty
	a_ext_bus: assert property (p_ext_bus)
		else $error("expansion bus address or strobe wrong");
	property p_boot_page;
		taken && serial_open_drain && cpu_addr[15:8] == 8'hbf && !cpu_direct
			|=> cpu_sel.boot || cpu_sel.regs || cpu_sel.ram;
	endproperty
	a_boot_page: assert property (p_boot_page)
		else $error("boot page not answered by boot rom");
	property p_no_boot;
		taken && !serial_open_drain |=> !cpu_sel.boot;
	endproperty
	a_no_boot: assert property (p_no_boot)
		else $error("boot rom selected outside bootstrap mode");
	property p_direct;
		taken && cpu_direct |=> !cpu_sel.nvm && !cpu_sel.boot;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct access left the lowest page");
	property p_jump;
		boot_jump |-> boot_jump_addr == 16'h0000 ##1 !boot_jump;
	endproperty
	a_jump: assert property (p_jump)
		else $error("boot jump target or pulse wrong");
	c_ext: cover property (cpu_sel.ext);
	c_boot: cover property (cpu_sel.boot);
	c_jump: cover property (boot_jump);
endmodule // mmd_decoder_sva
`default_nettype wire

/* File: mmd_cpu_model.sv */
/*
 cpu core model: issues one byte access per call and returns the answer.
 assumes the decoder answers one cycle after the taking edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_cpu_model
	import mmd_pkg::*;
(
	input wire logic clk_sys,
	output logic cpu_req,
	output logic [15:0] cpu_addr,
	output logic cpu_we,
	output logic [7:0] cpu_wdata,
	output logic cpu_vector,
	output logic cpu_direct,
	input wire mmd_sel_type cpu_sel,
	input wire logic [7:0] cpu_rdata,
	input wire mmd_exp_type exp_bus
);
	initial begin
		cpu_req = 1'b0;
		cpu_addr = 16'h0000;
		cpu_we = 1'b0;
		cpu_wdata = 8'h00;
		cpu_vector = 1'b0;
		cpu_direct = 1'b0;
	end
	// ==========================================================
	// one access; released address and write data are inverted so stale values never match
	task automatic access(input logic [15:0] a, input logic we,
		input logic [7:0] wd, input logic vec, input logic dir,
		output mmd_sel_type s, output logic [7:0] rd, output mmd_exp_type ex);
		@(posedge clk_sys);
		cpu_req <= 1'b1;
		cpu_addr <= a;
		cpu_we <= we;
		cpu_wdata <= wd;
		cpu_vector <= vec;
		cpu_direct <= dir;
		@(posedge clk_sys);
		cpu_req <= 1'b0;
		cpu_we <= 1'b0;
		cpu_addr <= ~a;
		cpu_wdata <= ~wd;
		@(posedge clk_sys);
		s = cpu_sel;
		rd = cpu_rdata;
		ex = exp_bus;
	endtask
endmodule // mmd_cpu_model
`default_nettype wire

/* File: tb_top.sv */
/*
 testbench for mmd_decoder: apb and cpu access sequences in all four modes.
 assumes mmd_cpu_model as the cpu and a short idle count for the loader.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mmd_pkg::*;
;
	localparam int IDLE = 50;
	localparam mmd_sel_type sel_reg = 6'h20, sel_ram = 6'h10, sel_boot = 6'h08;
	localparam mmd_sel_type sel_nvm = 6'h04, sel_ext = 6'h02, sel_none = 6'h01;
	logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, rx_data = 8'h00, cpu_rdata, cpu_wdata, rd_s;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic msl = 1'b0, msh = 1'b1, wake = 1'b0, rx_valid = 1'b0, err;
	logic pready, pslverr, cpu_req, cpu_we, cpu_vector, cpu_direct;
	logic serial_open_drain, boot_jump, clocks_halted;
	logic [15:0] cpu_addr, boot_jump_addr;
	mmd_sel_type cpu_sel, sel_s;
	mmd_exp_type exp_bus, ex_s;
	int miscompares = 0, tests_run = 0, n;
	always #10 clk_sys = ~clk_sys;
	mmd_decoder #(.IDLE_CYCLES(IDLE)) mmd_decoder_inst (.clk_sys(clk_sys),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_select_low(msl), .mode_select_high(msh),
		.cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
		.cpu_wdata(cpu_wdata), .cpu_vector(cpu_vector),
		.cpu_direct(cpu_direct), .wake(wake), .cpu_sel(cpu_sel),
		.cpu_rdata(cpu_rdata), .exp_bus(exp_bus), .rx_valid(rx_valid),
		.rx_data(rx_data), .serial_open_drain(serial_open_drain),
		.boot_jump(boot_jump), .boot_jump_addr(boot_jump_addr),
		.clocks_halted(clocks_halted));
	mmd_cpu_model mmd_cpu_model_inst (.clk_sys(clk_sys), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_wdata(cpu_wdata),
		.cpu_vector(cpu_vector), .cpu_direct(cpu_direct), .cpu_sel(cpu_sel),
		.cpu_rdata(cpu_rdata), .exp_bus(exp_bus));
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_sel(input mmd_sel_type e, input mmd_sel_type g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected cpu_sel expected %b seen %b", e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) miscompares++;
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cpu(input logic [15:0] a, input logic we, input logic [7:0] wd,
		input logic vec, input logic dir);
		mmd_cpu_model_inst.access(a, we, wd, vec, dir, sel_s, rd_s, ex_s);
	endtask
	task automatic probe(input logic [15:0] a, input logic vec, input logic dir,
		input mmd_sel_type e);
		cpu(a, 1'b0, 8'h00, vec, dir);
		chk_sel(e, sel_s);
	endtask
	// mode pins stay put until the next reset, past the freeze point
	task automatic do_reset(input mmd_mode_type m);
		rst <= 1'b1;
		msh <= m[1];
		msl <= m[0];
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic wait_jump(input int lim);
		n = 0;
		while (boot_jump !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic final_report;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		do_reset(MMD_MODE_SINGLE);
		apb(1'b0, MMD_OFS_MAP_POS, 32'h0);
		chk("map_pos", 32'h10, rdat);
		apb(1'b0, MMD_OFS_OPTION, 32'h0);
		chk("option", 32'h1f, rdat);
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		probe(16'h0000, 1'b0, 1'b0, sel_ram);
		probe(16'h105f, 1'b0, 1'b0, sel_reg);
		probe(16'h1060, 1'b0, 1'b0, sel_none);
		probe(16'hfe00, 1'b0, 1'b0, sel_nvm);
		probe(16'hbf00, 1'b0, 1'b0, sel_none);
		probe(16'h1234, 1'b0, 1'b1, sel_ram);
		cpu(16'h03ff, 1'b1, 8'h3c, 1'b0, 1'b0);
		apb(1'b1, MMD_OFS_OPTION, 32'h13);
		probe(16'h3e00, 1'b0, 1'b0, sel_none);
		probe(16'hfe00, 1'b0, 1'b0, sel_nvm);
		apb(1'b1, MMD_OFS_MAP_POS, 32'h0);
		probe(16'h005f, 1'b0, 1'b0, sel_reg);
		probe(16'h0060, 1'b0, 1'b0, sel_ram);
		apb(1'b1, MMD_OFS_CONTROL, 32'h1);
		probe(16'h03ff, 1'b0, 1'b0, 6'h00);
		chk("clocks_halted", 32'h1, 32'(clocks_halted));
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		cpu(16'h03ff, 1'b0, 8'h00, 1'b0, 1'b0);
		chk("ram after stop", 32'h3c, 32'(rd_s));
		$display("single-chip tests done");
		do_reset(MMD_MODE_EXPANDED);
		probe(16'h5a81, 1'b0, 1'b0, sel_ext);
		chk("exp addr", 32'h5a81,
			32'({ex_s.addr_high, ex_s.addr_low}));
		chk("exp rnw", 32'h1, 32'(ex_s.read_not_write));
		cpu(16'h5a82, 1'b1, 8'h69, 1'b0, 1'b0);
		chk("exp write", 32'h34d, 32'({ex_s.data_out, ex_s.data_oe,
			ex_s.read_not_write, ex_s.strobe}));
		probe(16'h1000, 1'b0, 1'b0, sel_reg);
		probe(16'hfe00, 1'b0, 1'b0, sel_nvm);
		apb(1'b1, MMD_OFS_OPTION, 32'h13);
		probe(16'h3e00, 1'b0, 1'b0, sel_nvm);
		probe(16'hfe00, 1'b0, 1'b0, sel_ext);
		$display("expanded tests done");
		do_reset(MMD_MODE_TEST);
		probe(16'hfe00, 1'b0, 1'b0, sel_ext);
		probe(16'hfffe, 1'b1, 1'b0, sel_ext);
		probe(16'hfd00, 1'b0, 1'b0, sel_none);
		apb(1'b1, MMD_OFS_OPTION, 32'h13);
		probe(16'h3e00, 1'b0, 1'b0, sel_nvm);
		probe(16'h3dff, 1'b0, 1'b0, sel_none);
		$display("test mode tests done");
		do_reset(MMD_MODE_BOOT);
		chk("open drain", 32'h1, 32'(serial_open_drain));
		for (int i = 0; i < 1024; i++) begin
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_data <= 8'(i) ^ 8'h5a;
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		wait_jump(4);
		chk("jump on last byte", 32'h1, 32'(boot_jump));
		chk("jump addr", 32'h0, 32'(boot_jump_addr));
		cpu(16'h0001, 1'b0, 8'h00, 1'b0, 1'b0);
		chk("loaded ram", 32'h5b, 32'(rd_s));
		cpu(16'h03ff, 1'b0, 8'h00, 1'b0, 1'b0);
		chk("loaded ram", 32'ha5, 32'(rd_s));
		apb(1'b0, MMD_OFS_STATUS, 32'h0);
		chk("loader state", 32'h3, 32'(rdat[5:4]));
		probe(16'hbf00, 1'b0, 1'b0, sel_boot);
		probe(16'hbf3f, 1'b0, 1'b0, sel_boot);
		cpu(16'hfffe, 1'b0, 8'h00, 1'b1, 1'b0);
		chk("reset vector", 32'hbf, 32'(rd_s));
		cpu(16'hffc1, 1'b0, 8'h00, 1'b1, 1'b0);
		chk("ram vector", 32'hc4, 32'(rd_s));
		do_reset(MMD_MODE_BOOT);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		wait_jump(IDLE + 20);
		chk("idle jump", 32'h1, 32'(boot_jump === 1'b1 && n > 30));
		$display("bootstrap tests done");
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		final_report;
	end
endmodule // tb_top
bind mmd_decoder mmd_decoder_sva mmd_decoder_sva_inst (.clk_sys(clk_sys),
	.rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
	.cpu_direct(cpu_direct), .cpu_sel(cpu_sel), .exp_bus(exp_bus),
	.serial_open_drain(serial_open_drain), .boot_jump(boot_jump),
	.boot_jump_addr(boot_jump_addr), .clocks_halted(clocks_halted));
`default_nettype wire
